// file: design/ldp_host_port.sv
// Display controller: host register/memory port, attributes, dimming
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// Function
// - Access needs select low, one strobe low
// - Low address picks digit, 000 leftmost
// - Bit 7 chooses ASCII or glyph index; stored only, never decoded
// - Index register: low four bits used
// - Index selected: flash high, A4 A3 low
// - Row picked by low address, five bits
// - Bit 0 rightmost column, bit 4 leftmost
// - Flash select low picks attribute memory
// - Data bit 0 sets or clears attribute
// - Bit 3 enables attribute flashing, div 28672
// - Control word at A4 high A3 low
// - Bits 0-2 brightness, 111 blanks display
// - Bit 4 blinks all, overrides flash
// - Brightness codes give listed duty levels
// - Bit 7 clears character and attribute memories, self-clears
// - Bit 6 self test, pass bit 5
// - Reset clears character and attribute memories, done in three clocks
module ldp_host_port
    import ldp_pkg::*;
(
    // Clock and control
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    clk_en,
    // Host bus pins
    input  wire logic                    chip_select_n,
    input  wire logic                    read_strobe_n,
    input  wire logic                    write_strobe_n,
    input  wire logic                    flash_select_n,
    input  wire logic [4:0]              addr,
    input  wire logic [7:0]              data_in,
    output logic      [7:0]              data_out,
    output logic                         data_oe,
    // Display state
    output logic      [NUM_DIGITS-1:0]   digit_on,
    output logic                         busy
);
    ldp_bus_t   bus;
    ldp_state_t state, next_state;
    logic [7:0] char_mem [NUM_DIGITS];
    logic [4:0] glyph_mem [NUM_GLYPHS*NUM_ROWS];
    logic [NUM_DIGITS-1:0] flash_mem, next_flash_mem;
    logic [7:0] ctrl, next_ctrl, glyph_index, next_glyph_index;
    logic [7:0] next_char_mem [NUM_DIGITS];
    logic [4:0] next_glyph_mem [NUM_GLYPHS*NUM_ROWS];
    logic [17:0] seq_cnt, next_seq_cnt;
    logic [14:0] blink_cnt, next_blink_cnt;
    logic        blink_phase, next_blink_phase;
    logic [3:0]  duty_cnt, next_duty_cnt;
    logic [7:0]  next_data_out;
    logic        next_data_oe, next_busy, wr_edge;
    logic [NUM_DIGITS-1:0] next_digit_on;

    ldp_sync #(.W(17), .INIT(17'h1ffff)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .d_async  ({chip_select_n, read_strobe_n, write_strobe_n,
                    flash_select_n, addr, data_in}),
        .q        (bus)
    );

    function automatic int glyph_slot(input logic [7:0] idx, input logic [2:0] row);
        glyph_slot = int'(idx[3:0]) * NUM_ROWS + int'(row);
    endfunction : glyph_slot

    function automatic logic [3:0] duty_of(input logic [2:0] code);
        duty_of = DUTY_TABLE[4 * (7 - int'(code)) +: 4];
    endfunction : duty_of

    //////////////////////////////////////////////////////////////////////////
    logic access_ok, wr_seen, is_write, is_read, wr_prev;
    assign access_ok = !bus.cs_n && (bus.rd_n != bus.wr_n);
    assign wr_seen   = access_ok && !bus.wr_n;
    // Writes while busy are dropped, not replayed once idle
    assign is_write  = wr_seen && state == ST_IDLE;
    assign is_read   = access_ok && !bus.rd_n;
    assign wr_edge   = is_write && !wr_prev;

    always_comb begin
        next_state       = state;
        next_ctrl        = ctrl;
        next_glyph_index = glyph_index;
        next_flash_mem   = flash_mem;
        next_char_mem    = char_mem;
        next_glyph_mem   = glyph_mem;
        next_seq_cnt     = seq_cnt;
        case (state)
            ST_INIT: begin
                next_seq_cnt = seq_cnt + 18'h1;
                if (seq_cnt == 18'(INIT_CYCLES - 1)) begin
                    next_state = ST_IDLE;
                end
            end
            ST_IDLE: begin
                next_seq_cnt = '0;
                if (wr_edge) begin
                    if (!bus.flash_sel_n) begin
                        next_flash_mem[bus.addr[2:0]] = bus.wdata[0];
                    end else begin
                        case (bus.addr[4:3])
                            SEL_INDEX: next_glyph_index = bus.wdata;
                            SEL_GLYPH: next_glyph_mem[glyph_slot(glyph_index,
                                       bus.addr[2:0])] = bus.wdata[4:0];
                            SEL_CTRL: begin
                                next_ctrl = bus.wdata;
                                next_ctrl[CTL_PASS] = ctrl[CTL_PASS];
                                if (bus.wdata[CTL_TEST]) next_state = ST_TEST;
                                else if (bus.wdata[CTL_CLEAR]) next_state = ST_CLEAR;
                            end
                            SEL_CHAR: next_char_mem[bus.addr[2:0]] = bus.wdata;
                            default: ;
                        endcase
                    end
                end
            end
            ST_CLEAR: begin
                next_seq_cnt = seq_cnt + 18'h1;
                if (seq_cnt == 18'(INIT_CYCLES - 1)) begin
                    for (int i = 0; i < NUM_DIGITS; i++) next_char_mem[i] = CHAR_SPACE;
                    next_flash_mem = '0;
                    next_ctrl[CTL_CLEAR] = 1'b0;
                    next_state = ST_IDLE;
                end
            end
            ST_TEST: begin
                next_seq_cnt = seq_cnt + 18'h1;
                if (seq_cnt == 18'(SELF_TEST_CYCLES - 1)) begin
                    for (int i = 0; i < NUM_DIGITS; i++) next_char_mem[i] = CHAR_SPACE;
                    next_flash_mem   = '0;
                    next_glyph_index = INDEX_ALL_ONES;
                    next_ctrl        = CTRL_RESET;
                    next_ctrl[CTL_PASS] = SELF_TEST_PASS;
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_INIT;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_data_oe  = is_read;
        next_data_out = '0;
        if (is_read) begin
            if (!bus.flash_sel_n) begin
                next_data_out = {7'h00, flash_mem[bus.addr[2:0]]};
            end else begin
                case (bus.addr[4:3])
                    SEL_INDEX: next_data_out = glyph_index;
                    SEL_GLYPH: next_data_out = {3'h0,
                               glyph_mem[glyph_slot(glyph_index, bus.addr[2:0])]};
                    SEL_CTRL:  next_data_out = ctrl;
                    SEL_CHAR:  next_data_out = char_mem[bus.addr[2:0]];
                    default:   next_data_out = '0;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_blink_cnt   = blink_cnt + 15'h1;
        next_blink_phase = blink_phase;
        if (blink_cnt == 15'(HALF_FLASH - 1)) begin
            next_blink_cnt   = '0;
            next_blink_phase = !blink_phase;
        end
        next_duty_cnt = (duty_cnt == 4'(DUTY_STEPS - 1)) ? 4'h0 : duty_cnt + 4'h1;
        for (int i = 0; i < NUM_DIGITS; i++) begin
            // Char source bit kept; drive uses only brightness, blink, flash and the init state, no glyph lookup
            next_digit_on[i] = (duty_cnt < duty_of(ctrl[2:0]))
                && (ctrl[2:0] != BRIGHT_BLANK)
                && !(ctrl[CTL_BLINK] && blink_phase)
                && !(!ctrl[CTL_BLINK] && ctrl[CTL_FLASH_EN] && flash_mem[i] && blink_phase)
                && (state != ST_INIT);
        end
        next_busy = (next_state != ST_IDLE);
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state       <= ST_INIT;
            ctrl        <= CTRL_RESET;
            flash_mem   <= '0;
            for (int i = 0; i < NUM_DIGITS; i++) char_mem[i] <= CHAR_SPACE;
            seq_cnt     <= '0;
            blink_cnt   <= '0;
            blink_phase <= 1'b0;
            duty_cnt    <= '0;
            data_out    <= '0;
            data_oe     <= 1'b0;
            digit_on    <= '0;
            busy        <= 1'b1;
            wr_prev     <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            ctrl        <= next_ctrl;
            flash_mem   <= next_flash_mem;
            char_mem    <= next_char_mem;
            seq_cnt     <= next_seq_cnt;
            blink_cnt   <= next_blink_cnt;
            blink_phase <= next_blink_phase;
            duty_cnt    <= next_duty_cnt;
            data_out    <= next_data_out;
            data_oe     <= next_data_oe;
            digit_on    <= next_digit_on;
            busy        <= next_busy;
            wr_prev     <= wr_seen;
        end
    end

    // Glyph memory and index keep their contents through reset
    always_ff @(posedge core_clk) begin
        if (clk_en) begin
            glyph_index <= next_glyph_index;
            glyph_mem   <= next_glyph_mem;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    property p_read_oe;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && is_read |=> data_oe;
    endproperty
    a_read_oe: assert property (p_read_oe) else $error("read not driven");

    property p_no_oe;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && !is_read |=> !data_oe;
    endproperty
    a_no_oe: assert property (p_no_oe) else $error("bus driven idle");

    property p_blank;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && ctrl[2:0] == BRIGHT_BLANK |=> digit_on == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("blank code lit");

    property p_blink;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && ctrl[CTL_BLINK] && blink_phase |=> digit_on == '0;
    endproperty
    a_blink: assert property (p_blink) else $error("blink off phase lit");

    property p_clear_done;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && state == ST_CLEAR && seq_cnt == 18'(INIT_CYCLES - 1)
        |=> char_mem[0] == CHAR_SPACE && flash_mem == '0 && !ctrl[CTL_CLEAR];
    endproperty
    a_clear_done: assert property (p_clear_done) else $error("clear failed");

    property p_test_done;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && state == ST_TEST && seq_cnt == 18'(SELF_TEST_CYCLES - 1)
        |=> glyph_index == INDEX_ALL_ONES && ctrl == 8'h20;
    endproperty
    a_test_done: assert property (p_test_done) else $error("self test end");

    property p_flash_wr;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && wr_edge && !bus.flash_sel_n
        |=> flash_mem[$past(bus.addr[2:0])] == $past(bus.wdata[0]);
    endproperty
    a_flash_wr: assert property (p_flash_wr) else $error("flash write");

    property p_ctrl_wr;
        @(posedge core_clk) disable iff (!rst_n)
        clk_en && wr_edge && bus.flash_sel_n && bus.addr[4:3] == SEL_CTRL
        |=> ctrl[4:0] == $past(bus.wdata[4:0]);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("ctrl write");

    property p_init;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> busy;
    endproperty
    a_init: assert property (p_init) else $error("not busy after reset");

    c_clear: cover property (@(posedge core_clk) state == ST_CLEAR);
    c_test:  cover property (@(posedge core_clk) state == ST_TEST);
    c_read:  cover property (@(posedge core_clk) data_oe);
    c_blink: cover property (@(posedge core_clk) ctrl[CTL_BLINK] && blink_phase);
endmodule : ldp_host_port

// file: design/ldp_pkg.sv
// Package: constants and types for the display host port
package ldp_pkg;
    localparam int          CLK_MHZ          = 100;
    localparam int          NUM_DIGITS       = 8;
    localparam int          NUM_GLYPHS       = 16;
    localparam int          NUM_ROWS         = 7;
    localparam int          FLASH_DIV        = 28672;
    localparam int          HALF_FLASH       = FLASH_DIV / 2;
    localparam int          SELF_TEST_CYCLES = 262144;
    localparam int          INIT_CYCLES      = 3;
    localparam logic [7:0]  CHAR_SPACE       = 8'h20;
    localparam logic [7:0]  CTRL_RESET       = 8'h00;
    localparam logic [7:0]  INDEX_ALL_ONES   = 8'hff;
    // Address decode, flash_select_n high, addr[4:3]
    localparam logic [1:0]  SEL_INDEX        = 2'h0;
    localparam logic [1:0]  SEL_GLYPH        = 2'h1;
    localparam logic [1:0]  SEL_CTRL         = 2'h2;
    localparam logic [1:0]  SEL_CHAR         = 2'h3;
    // Control word fields
    localparam int          CTL_BRIGHT_LSB   = 0;
    localparam int          CTL_FLASH_EN     = 3;
    localparam int          CTL_BLINK        = 4;
    localparam int          CTL_PASS         = 5;
    localparam int          CTL_TEST         = 6;
    localparam int          CTL_CLEAR        = 7;
    localparam int          CHAR_SRC_BIT     = 7;
    localparam logic [2:0]  BRIGHT_BLANK     = 3'h7;
    // Duty in steps of a 15-step frame: 15,12,8,6,4,3,2,0
    localparam int          DUTY_STEPS       = 15;
    localparam logic [31:0] DUTY_TABLE       = 32'hfc86_4320;
    localparam logic        SELF_TEST_PASS   = 1'b1;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       flash_sel_n;
        logic [4:0] addr;
        logic [7:0] wdata;
    } ldp_bus_t;

    typedef struct packed {
        logic [7:0] rdata;
        logic       oe;
    } ldp_rd_t;

    typedef enum logic [3:0] {
        ST_INIT  = 4'b0001,
        ST_IDLE  = 4'b0010,
        ST_CLEAR = 4'b0100,
        ST_TEST  = 4'b1000
    } ldp_state_t;
endpackage : ldp_pkg

// file: design/ldp_sync.sv
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
module ldp_sync
    import ldp_pkg::*;
#(
    parameter int          W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and control
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    // Data
    input  wire logic [W-1:0] d_async,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1, s2, s3;
    logic [W-1:0] next_q;

    always_comb begin
        next_q = q;
        for (int i = 0; i < W; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s2[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q  <= INIT;
        end else if (clk_en) begin
            s1 <= d_async;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule : ldp_sync

// file: tb/ldp_host_model.sv
// Host microprocessor model driving the parallel display port
`timescale 1ns/1ns
module ldp_host_model
    import ldp_pkg::*;
(
    // Clock
    input  wire logic       core_clk,
    // Bus pins
    output ldp_bus_t        bus,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe
);
    initial begin
        bus = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, flash_sel_n: 1'b1, addr: 5'h0, wdata: 8'h0};
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    // Address settles a cycle before select and outlives it
    task automatic wr(input logic f, input logic [4:0] a, input logic [7:0] d);
        tick(1);
        bus.flash_sel_n = f;
        bus.addr        = a;
        bus.wdata       = d;
        tick(1);
        bus.cs_n = 1'b0;
        bus.wr_n = 1'b0;
        tick(8);
        bus.cs_n = 1'b1;
        bus.wr_n = 1'b1;
        tick(1);
        // Released lines no longer show the last value
        bus.wdata = ~d;
        tick(6);
    endtask : wr

    task automatic rd(input logic f, input logic [4:0] a, output logic [7:0] d, output bit ok);
        tick(1);
        bus.flash_sel_n = f;
        bus.addr        = a;
        tick(1);
        bus.cs_n = 1'b0;
        bus.rd_n = 1'b0;
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++) begin
            @(posedge core_clk);
            #1;
            ok = (data_oe === 1'b1);
            d  = data_out;
        end
        bus.cs_n = 1'b1;
        bus.rd_n = 1'b1;
        tick(8);
    endtask : rd
endmodule : ldp_host_model

// file: tb/testbench.sv
// Self-checking bench for the display host port
`timescale 1ns/1ns
module testbench;
    import ldp_pkg::*;
    logic       core_clk;
    logic       rst_n;
    logic       clk_en;
    ldp_bus_t   hb;
    logic [7:0] data_out;
    logic       data_oe;
    logic [7:0] digit_on;
    logic       busy;
    int         err_total;
    int         comparisons;
    int         char_m [8];
    int         flash_m [8];
    int         glyph_m [16][7];
    int         index_m;
    logic [7:0] v;
    logic [7:0] off;
    logic [7:0] on;
    logic [7:0] fl_exp;
    int         mixed;
    int         cnt;

    ldp_host_port ldp_host_port_inst (
        .core_clk       (core_clk),
        .rst_n          (rst_n),
        .clk_en         (clk_en),
        .chip_select_n  (hb.cs_n),
        .read_strobe_n  (hb.rd_n),
        .write_strobe_n (hb.wr_n),
        .flash_select_n (hb.flash_sel_n),
        .addr           (hb.addr),
        .data_in        (hb.wdata),
        .data_out       (data_out),
        .data_oe        (data_oe),
        .digit_on       (digit_on),
        .busy           (busy)
    );

    ldp_host_model ldp_host_model_inst (
        .core_clk (core_clk),
        .bus      (hb),
        .data_out (data_out),
        .data_oe  (data_oe)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            err_total++;
        end
    endtask : check

    task automatic print_verdict();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    task automatic hang(input string name);
        $display("ERROR %s expected done seen timeout", name);
        err_total++;
        print_verdict();
    endtask : hang

    task automatic wait_idle();
        for (int n = 0; busy !== 1'b0; n++) begin
            if (n > 50) hang("busy");
            @(posedge core_clk);
            #1;
        end
    endtask : wait_idle

    task automatic cwr(input logic f, input logic [4:0] a, input logic [7:0] d);
        if (!f) flash_m[a[2:0]] = d[0];
        else if (a[4:3] == SEL_INDEX) index_m = d;
        else if (a[4:3] == SEL_GLYPH) glyph_m[index_m[3:0]][a[2:0]] = d[4:0];
        else if (a[4:3] == SEL_CHAR) char_m[a[2:0]] = d;
        ldp_host_model_inst.wr(f, a, d);
    endtask : cwr

    task automatic crd(input string name, input logic f, input logic [4:0] a,
                       input logic [7:0] exp, input logic [7:0] m);
        logic [7:0] d;
        bit         ok;
        ldp_host_model_inst.rd(f, a, d, ok);
        if (!ok) hang(name);
        check(name, 16'(d & m), 16'(exp & m));
        check("oe_idle", 16'(data_oe), 16'h0);
        check("dout_idle", 16'(data_out), 16'h0);
    endtask : crd

    // Lit state of every digit over a window
    task automatic watch(input int n);
        off   = 8'h0;
        on    = 8'h0;
        mixed = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            off |= ~digit_on;
            on  |= digit_on;
            if (digit_on !== 8'h00 && digit_on !== 8'hff) mixed++;
        end
    endtask : watch

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n       = 1'b0;
        clk_en      = 1'b1;
        err_total   = 0;
        comparisons = 0;
        index_m     = 0;
        void'($urandom(32'hcf84));
        repeat (12) @(posedge core_clk);
        #1;
        check("busy_rst", 16'(busy), 16'h1);
        rst_n = 1'b1;
        wait_idle();
        foreach (char_m[i]) char_m[i] = CHAR_SPACE;
        foreach (flash_m[i]) flash_m[i] = 0;
        for (int i = 0; i < 8; i++) begin
            crd("char_rst", 1'b1, {SEL_CHAR, 3'(i)}, CHAR_SPACE, 8'hff);
            crd("flash_rst", 1'b0, 5'(i), 8'h0, 8'h01);
        end
        crd("ctrl_rst", 1'b1, {SEL_CTRL, 3'h0}, CTRL_RESET, 8'hff);
        $display("Test reset done");

        for (int i = 0; i < 8; i++) cwr(1'b1, {SEL_CHAR, 3'(i)}, 8'($urandom));
        for (int i = 0; i < 8; i++) begin
            crd("char", 1'b1, {SEL_CHAR, 3'(i)}, 8'(char_m[i]), 8'hff);
        end
        $display("Test character memory done");

        for (int g = 0; g < 2; g++) begin
            cwr(1'b1, {SEL_INDEX, 3'($urandom)}, 8'($urandom));
            crd("index", 1'b1, {SEL_INDEX, 3'($urandom)}, 8'(index_m), 8'h0f);
            for (int r = 0; r < NUM_ROWS; r++) cwr(1'b1, {SEL_GLYPH, 3'(r)}, 8'($urandom));
            for (int r = 0; r < NUM_ROWS; r++) begin
                v = 8'(glyph_m[index_m[3:0]][r]);
                crd("glyph", 1'b1, {SEL_GLYPH, 3'(r)}, v, 8'h1f);
            end
        end
        $display("Test glyph memory done");

        for (int i = 0; i < 8; i++) cwr(1'b0, {2'($urandom), 3'(i)}, 8'($urandom));
        for (int i = 0; i < 8; i++) begin
            crd("flash", 1'b0, {2'($urandom), 3'(i)}, 8'(flash_m[i]), 8'h01);
            fl_exp[i] = flash_m[i][0];
        end
        $display("Test flash memory done");

        cwr(1'b1, {SEL_CTRL, 3'h5}, 8'h1b);
        cwr(1'b1, {SEL_CTRL, 3'h2}, 8'h04);
        crd("ctrl", 1'b1, {SEL_CTRL, 3'h0}, 8'h04, 8'hdf);
        for (int c = 0; c < 8; c++) begin
            cwr(1'b1, {SEL_CTRL, 3'h0}, 8'(c));
            cnt = 0;
            repeat (DUTY_STEPS * 100) begin
                @(posedge core_clk);
                #1;
                cnt += int'(digit_on[7]);
            end
            check("duty", 16'(cnt), 16'(100 * DUTY_TABLE[28 - 4 * c +: 4]));
        end
        $display("Test brightness done");

        cwr(1'b1, {SEL_CTRL, 3'h0}, 8'h08);
        watch(FLASH_DIV + 100);
        check("flash_off", 16'(off), 16'(fl_exp));
        check("flash_on", 16'(on), 16'hff);
        cwr(1'b1, {SEL_CTRL, 3'h0}, 8'h18);
        watch(FLASH_DIV + 100);
        check("blink_off", 16'(off), 16'hff);
        check("blink_on", 16'(on), 16'hff);
        check("blink_mixed", 16'(mixed), 16'h0);
        $display("Test flash and blink done");

        cwr(1'b1, {SEL_CTRL, 3'h0}, 8'h98);
        wait_idle();
        crd("ctrl_clr", 1'b1, {SEL_CTRL, 3'h0}, 8'h18, 8'hdf);
        for (int i = 0; i < 8; i++) begin
            crd("char_clr", 1'b1, {SEL_CHAR, 3'(i)}, CHAR_SPACE, 8'hff);
            crd("flash_clr", 1'b0, 5'(i), 8'h0, 8'h01);
        end
        $display("Test clear done");

        cwr(1'b1, {SEL_CHAR, 3'h2}, 8'h41);
        cwr(1'b0, 5'h2, 8'h01);
        rst_n = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("busy_rst2", 16'(busy), 16'h1);
        rst_n = 1'b1;
        wait_idle();
        foreach (char_m[i]) char_m[i] = CHAR_SPACE;
        foreach (flash_m[i]) flash_m[i] = 0;
        crd("char_rst2", 1'b1, {SEL_CHAR, 3'h2}, 8'(char_m[2]), 8'hff);
        crd("flash_rst2", 1'b0, 5'h2, 8'(flash_m[2]), 8'h01);
        crd("ctrl_rst2", 1'b1, {SEL_CTRL, 3'h0}, CTRL_RESET, 8'hff);
        crd("index_keep", 1'b1, {SEL_INDEX, 3'h0}, 8'(index_m), 8'h0f);
        v = 8'(glyph_m[index_m[3:0]][0]);
        crd("glyph_keep", 1'b1, {SEL_GLYPH, 3'h0}, v, 8'h1f);
        $display("Test reset keep done");

        // Dimmed drive toggles within a frame unless frozen
        cwr(1'b1, {SEL_CTRL, 3'h0}, 8'h01);
        clk_en = 1'b0;
        v      = digit_on;
        repeat (30) begin
            @(posedge core_clk);
            #1;
            check("freeze", 16'(digit_on), 16'(v));
        end
        clk_en = 1'b1;
        $display("Test clock enable done");
        print_verdict();
    end
endmodule : testbench
